// ===== ats_autoscan.sv
// The APB register port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - Scan runs only while scan enable set
// - Trigger field chooses source; 0110 first timer
// - First timer keeps triggering scans in Sleep
// - Timers trigger correctly in Idle too
// - External interrupt zero triggers, also in Sleep
// - Mode 11 interrupts on every channel hit
// - Bitmaps select channels, one bit each
// - Valid comparison sets pollable channel hit bit
module ats_autoscan
  import ats_pkg::*;
(
  input  wire logic          pclk,
  input  wire logic          presetn,
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [7:0]    paddr,
  input  wire logic [31:0]   pwdata,
  output logic      [31:0]   prdata,
  output logic               pready,
  output logic               pslverr,
  input  wire logic          sleep_mode,
  input  wire logic          idle_mode,
  input  wire logic          first_timer_evt,
  input  wire logic          other_timer_evt,
  input  wire logic          external_interrupt_zero,
  output ats_conv_req_t      conv_req,
  input  wire ats_conv_rsp_t conv_rsp,
  output logic               irq
);

  // ---------------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------------
  logic [3:0]        trig_src_q;
  logic              scan_en_q;
  logic [1:0]        imode_q;
  logic              cmp_above_q;
  logic [NUM_CH-1:0] sel_q;
  logic [RES_W-1:0]  thr_q;
  logic [NUM_CH-1:0] hit_q;
  logic [INT_W-1:0]  int_stat_q;
  logic [INT_W-1:0]  int_mask_q;
  logic              sw_trig_q;
  logic              ext_s1_q;
  logic              ext_s2_q;
  logic              ext_s3_q;
  ats_state_t        state_q;
  ats_conv_req_t     conv_q;
  logic              scan_hit_q;
  logic [31:0]       prdata_q;
  logic              pready_q;
  logic              pslverr_q;
  logic              irq_q;

  // Lowest selected channel at or above a start index
  function automatic logic [CH_W:0] next_chan(input logic [NUM_CH-1:0] sel,
                                              input logic [CH_W:0]     from);
    logic [CH_W:0] res;
    res = '0;
    for (int i = NUM_CH - 1; i >= 0; i--) begin
      if (sel[i] && (CH_W+1)'(i) >= from) begin
        res = {1'b1, CH_W'(i)};
      end
    end
    return res;
  endfunction : next_chan

  // ---------------------------------------------------------------------------
  // APB slave
  // ---------------------------------------------------------------------------
  logic        wr_en;
  logic        acc_go;
  logic        mapped;
  logic [31:0] rdata_d;
  logic [NUM_CH-1:0] hit_clr;
  logic [INT_W-1:0]  int_clr;

  // One wait state: answer lands the cycle after access starts
  assign acc_go = psel && penable && !pready_q;
  assign wr_en  = psel && penable && pready_q && pwrite && !pslverr_q;

  always_comb begin
    mapped  = 1'b1;
    rdata_d = RST_WORD;
    unique case (paddr)
      OFF_CTRL_ONE:  rdata_d[CTRL1_TRIG_LSB +: 4] = trig_src_q;
      OFF_CTRL_FIVE: begin
        rdata_d[CTRL5_SCAN_BIT]         = scan_en_q;
        rdata_d[CTRL5_IMODE_LSB +: 2]   = imode_q;
        rdata_d[CTRL5_CMP_BIT]          = cmp_above_q;
      end
      OFF_SEL_LOW:   rdata_d[15:0]        = sel_q[15:0];
      OFF_SEL_HIGH:  rdata_d[15:0]        = sel_q[31:16];
      OFF_THRESH:    rdata_d[RES_W-1:0]   = thr_q;
      OFF_HIT_LOW:   rdata_d[15:0]        = hit_q[15:0];
      OFF_HIT_HIGH:  rdata_d[15:0]        = hit_q[31:16];
      OFF_INT_STAT:  rdata_d[INT_W-1:0]   = int_stat_q;
      OFF_INT_MASK:  rdata_d[INT_W-1:0]   = int_mask_q;
      OFF_STATUS: begin
        rdata_d[STAT_BUSY_BIT]          = (state_q == ATS_ST_WAIT);
        rdata_d[STAT_CH_LSB +: CH_W]    = conv_q.channel;
      end
      default:       mapped               = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= RST_WORD;
    end else begin
      pready_q  <= acc_go;
      pslverr_q <= acc_go && !mapped;
      if (acc_go && !pwrite) begin
        prdata_q <= rdata_d;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trig_src_q  <= TRIG_SOFT;
      scan_en_q   <= 1'b0;
      imode_q     <= IMODE_NONE;
      cmp_above_q <= 1'b0;
      sel_q       <= '0;
      thr_q       <= '0;
      int_mask_q  <= '0;
      sw_trig_q   <= 1'b0;
    end else begin
      sw_trig_q <= wr_en && paddr == OFF_CTRL_ONE && pwdata[CTRL1_SWTRIG_BIT];
      if (wr_en) begin
        unique case (paddr)
          OFF_CTRL_ONE:  trig_src_q <= pwdata[CTRL1_TRIG_LSB +: 4];
          OFF_CTRL_FIVE: begin
            scan_en_q   <= pwdata[CTRL5_SCAN_BIT];
            imode_q     <= pwdata[CTRL5_IMODE_LSB +: 2];
            cmp_above_q <= pwdata[CTRL5_CMP_BIT];
          end
          OFF_SEL_LOW:   sel_q[15:0]  <= pwdata[15:0];
          OFF_SEL_HIGH:  sel_q[31:16] <= pwdata[15:0];
          OFF_THRESH:    thr_q        <= pwdata[RES_W-1:0];
          OFF_INT_MASK:  int_mask_q   <= pwdata[INT_W-1:0];
          default: ;
        endcase
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Trigger selection
  // ---------------------------------------------------------------------------
  logic ext_rise;
  logic trig_evt;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_s1_q <= 1'b0;
      ext_s2_q <= 1'b0;
      ext_s3_q <= 1'b0;
    end else begin
      ext_s1_q <= external_interrupt_zero;
      ext_s2_q <= ext_s1_q;
      ext_s3_q <= ext_s2_q;
    end
  end

  assign ext_rise = ext_s2_q && !ext_s3_q;

  // First timer and pin stay live in Sleep; other timers halt there but run in Idle
  always_comb begin
    unique case (trig_src_q)
      TRIG_SOFT:        trig_evt = sw_trig_q;
      TRIG_EXT_EXTERNAL_INTERRUPT_ZERO:    trig_evt = ext_rise;
      TRIG_FIRST_TIMER: trig_evt = first_timer_evt;
      TRIG_OTHER_TIMER: trig_evt = other_timer_evt && !sleep_mode;
      default:          trig_evt = 1'b0;
    endcase
  end

  // ---------------------------------------------------------------------------
  // Scan sequencer
  // ---------------------------------------------------------------------------
  logic [CH_W:0] first_ch;
  logic [CH_W:0] after_ch;
  logic          launch;
  logic          done_now;
  logic          hit_now;
  logic          scan_end;

  assign first_ch = next_chan(sel_q, '0);
  assign after_ch = next_chan(sel_q, {1'b0, conv_q.channel} + 1'b1);
  assign launch   = state_q == ATS_ST_IDLE && scan_en_q && trig_evt && first_ch[CH_W];
  assign done_now = state_q == ATS_ST_WAIT && conv_rsp.done;
  assign hit_now  = done_now && (cmp_above_q ? conv_rsp.result >= thr_q
                                             : conv_rsp.result <  thr_q);
  assign scan_end = done_now && !after_ch[CH_W];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q    <= ATS_ST_IDLE;
      conv_q     <= '0;
      scan_hit_q <= 1'b0;
    end else begin
      conv_q.start <= 1'b0;
      unique case (state_q)
        ATS_ST_IDLE: begin
          if (launch) begin
            state_q        <= ATS_ST_WAIT;
            conv_q.start   <= 1'b1;
            conv_q.channel <= first_ch[CH_W-1:0];
            scan_hit_q     <= 1'b0;
          end
        end
        ATS_ST_WAIT: begin
          // Dropping scan enable abandons the sequence at once
          if (!scan_en_q) begin
            state_q <= ATS_ST_IDLE;
          end else if (done_now) begin
            scan_hit_q <= scan_hit_q || hit_now;
            if (after_ch[CH_W]) begin
              conv_q.start   <= 1'b1;
              conv_q.channel <= after_ch[CH_W-1:0];
            end else begin
              state_q <= ATS_ST_IDLE;
            end
          end
        end
      endcase
    end
  end

  // ---------------------------------------------------------------------------
  // Hit flags and interrupt
  // ---------------------------------------------------------------------------
  logic [NUM_CH-1:0] hit_set;
  logic [INT_W-1:0]  int_set;

  assign hit_clr = (wr_en && paddr == OFF_HIT_LOW)  ? {16'h0000, pwdata[15:0]} :
                   (wr_en && paddr == OFF_HIT_HIGH) ? {pwdata[15:0], 16'h0000} : '0;
  assign int_clr = (wr_en && paddr == OFF_INT_STAT) ? pwdata[INT_W-1:0] : '0;
  assign hit_set = hit_now ? (NUM_CH'(1) << conv_q.channel) : '0;

  // Highest channel gets no special case: every hit counts alike
  assign int_set[INT_CMP_BIT]  = hit_now && imode_q == IMODE_EACH;
  assign int_set[INT_DONE_BIT] = scan_end && (imode_q == IMODE_END ||
                                 (imode_q == IMODE_END_HIT && (scan_hit_q || hit_now)));

  // Set wins over a same-cycle clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hit_q      <= '0;
      int_stat_q <= '0;
      irq_q      <= 1'b0;
    end else begin
      hit_q      <= (hit_q & ~hit_clr) | hit_set;
      int_stat_q <= (int_stat_q & ~int_clr) | int_set;
      irq_q      <= |(((int_stat_q & ~int_clr) | int_set) & int_mask_q);
    end
  end

  assign prdata   = prdata_q;
  assign pready   = pready_q;
  assign pslverr  = pslverr_q;
  assign conv_req = conv_q;
  assign irq      = irq_q;

  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_scan_gate;
    state_q == ATS_ST_IDLE && !scan_en_q |=> !conv_q.start;
  endproperty
  a_scan_gate: assert property (p_scan_gate) else $error("Scan started while disabled");

  property p_timer_src;
    state_q == ATS_ST_IDLE && scan_en_q && |sel_q && trig_src_q == TRIG_FIRST_TIMER
      && first_timer_evt |=> conv_q.start && state_q == ATS_ST_WAIT;
  endproperty
  a_timer_src: assert property (p_timer_src) else $error("First timer did not start scan");

  property p_sleep_timer;
    sleep_mode && launch && trig_src_q == TRIG_FIRST_TIMER |=> conv_q.start;
  endproperty
  a_sleep_timer: assert property (p_sleep_timer) else $error("Sleep timer scan lost");

  property p_idle_other;
    idle_mode && !sleep_mode && state_q == ATS_ST_IDLE && scan_en_q && |sel_q
      && trig_src_q == TRIG_OTHER_TIMER && other_timer_evt |=> conv_q.start;
  endproperty
  a_idle_other: assert property (p_idle_other) else $error("Idle timer trigger lost");

  property p_ext_pin;
    $rose(ext_s2_q) && state_q == ATS_ST_IDLE && scan_en_q && |sel_q
      && trig_src_q == TRIG_EXT_EXTERNAL_INTERRUPT_ZERO |=> conv_q.start;
  endproperty
  a_ext_pin: assert property (p_ext_pin) else $error("Pin trigger lost");

  property p_each_irq;
    hit_now && imode_q == IMODE_EACH |=> int_stat_q[INT_CMP_BIT] ##1 (irq_q || !int_mask_q[0]);
  endproperty
  a_each_irq: assert property (p_each_irq) else $error("Per-channel interrupt missed");

  property p_sel_chan;
    conv_q.start |-> sel_q[conv_q.channel] || $past(wr_en);
  endproperty
  a_sel_chan: assert property (p_sel_chan) else $error("Unselected channel converted");

  property p_hit_flag;
    hit_now |=> hit_q[$past(conv_q.channel)];
  endproperty
  a_hit_flag: assert property (p_hit_flag) else $error("Hit flag not set");

  property p_ascend;
    done_now && scan_en_q && after_ch[CH_W] |=> conv_q.start
      && conv_q.channel > $past(conv_q.channel);
  endproperty
  a_ascend: assert property (p_ascend) else $error("Scan order not ascending");

  property p_abort;
    state_q == ATS_ST_WAIT && !scan_en_q |=> state_q == ATS_ST_IDLE && !conv_q.start;
  endproperty
  a_abort: assert property (p_abort) else $error("Scan ran on after disable");

  property p_busy_hold;
    state_q == ATS_ST_WAIT && !done_now |=> !conv_q.start;
  endproperty
  a_busy_hold: assert property (p_busy_hold) else $error("Start while converting");

  c_full_scan: cover property (launch ##[1:200] scan_end);
  c_each_irq:  cover property (hit_now && imode_q == IMODE_EACH ##2 irq_q);
  c_sleep_ext: cover property (sleep_mode && launch && trig_src_q == TRIG_EXT_EXTERNAL_INTERRUPT_ZERO);
  c_abort:     cover property (state_q == ATS_ST_WAIT && !scan_en_q);
  c_end_irq:   cover property (int_set[INT_DONE_BIT] ##2 irq_q);

endmodule : ats_autoscan

`default_nettype wire

// ===== ats_pkg.sv
package ats_pkg;

  // ---------------------------------------------------------------------------
  // Sizes
  // ---------------------------------------------------------------------------
  localparam int NUM_CH = 32;
  localparam int CH_W   = 5;
  localparam int RES_W  = 12;
  localparam int INT_W  = 2;

  // ---------------------------------------------------------------------------
  // Register byte offsets
  // ---------------------------------------------------------------------------
  localparam logic [7:0] OFF_CTRL_ONE  = 8'h00;
  localparam logic [7:0] OFF_CTRL_FIVE = 8'h04;
  localparam logic [7:0] OFF_SEL_LOW   = 8'h08;
  localparam logic [7:0] OFF_SEL_HIGH  = 8'h0C;
  localparam logic [7:0] OFF_THRESH    = 8'h10;
  localparam logic [7:0] OFF_HIT_LOW   = 8'h14;
  localparam logic [7:0] OFF_HIT_HIGH  = 8'h18;
  localparam logic [7:0] OFF_INT_STAT  = 8'h1C;
  localparam logic [7:0] OFF_INT_MASK  = 8'h20;
  localparam logic [7:0] OFF_STATUS    = 8'h24;

  // ---------------------------------------------------------------------------
  // Field positions and reset values
  // ---------------------------------------------------------------------------
  localparam int CTRL1_SWTRIG_BIT = 1;
  localparam int CTRL1_TRIG_LSB   = 4;
  localparam int CTRL5_CMP_BIT    = 0;
  localparam int CTRL5_IMODE_LSB  = 8;
  localparam int CTRL5_SCAN_BIT   = 15;
  localparam int INT_CMP_BIT      = 0;
  localparam int INT_DONE_BIT     = 1;
  localparam int STAT_BUSY_BIT    = 0;
  localparam int STAT_CH_LSB      = 8;
  localparam logic [31:0] RST_WORD = 32'h0000_0000;

  // ---------------------------------------------------------------------------
  // Trigger sources and interrupt modes
  // ---------------------------------------------------------------------------
  localparam logic [3:0] TRIG_SOFT        = 4'h0;
  localparam logic [3:0] TRIG_EXT_EXTERNAL_INTERRUPT_ZERO    = 4'h1;
  localparam logic [3:0] TRIG_FIRST_TIMER = 4'h6;
  localparam logic [3:0] TRIG_OTHER_TIMER = 4'h7;
  localparam logic [1:0] IMODE_NONE       = 2'h0;
  localparam logic [1:0] IMODE_END        = 2'h1;
  localparam logic [1:0] IMODE_END_HIT    = 2'h2;
  localparam logic [1:0] IMODE_EACH       = 2'h3;

  typedef enum logic {ATS_ST_IDLE, ATS_ST_WAIT} ats_state_t;

  typedef struct packed {
    logic            start;
    logic [CH_W-1:0] channel;
  } ats_conv_req_t;

  typedef struct packed {
    logic             done;
    logic [RES_W-1:0] result;
  } ats_conv_rsp_t;

endpackage : ats_pkg

// ===== ats_autoscan_tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module ats_autoscan_tb_top;
  import ats_pkg::*;

  logic          pclk;
  logic          presetn;
  logic          psel;
  logic          penable;
  logic          pwrite;
  logic [7:0]    paddr;
  logic [31:0]   pwdata;
  logic [31:0]   prdata;
  logic          pready;
  logic          pslverr;
  logic          sleep_mode;
  logic          idle_mode;
  logic          first_timer_evt;
  logic          other_timer_evt;
  logic          external_interrupt_zero;
  ats_conv_req_t conv_req;
  ats_conv_rsp_t conv_rsp;
  logic          irq;
  int            miscompares;
  int            n_compared;
  logic [31:0]   rd;
  logic          er;

  ats_autoscan dut_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sleep_mode(sleep_mode), .idle_mode(idle_mode), .first_timer_evt(first_timer_evt),
    .other_timer_evt(other_timer_evt), .external_interrupt_zero(external_interrupt_zero),
    .conv_req(conv_req), .conv_rsp(conv_rsp), .irq(irq)
  );

  always #12.5 pclk = ~pclk;

  // ---------------------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------------------
  task automatic close_out();
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : close_out

  task automatic timeout();
    miscompares++;
    $display("[FAIL] wait limit reached");
    close_out();
  endtask : timeout

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // Request held until the edge that samples pready high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (i == 20) timeout();
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk(nm, rd, exp);
  endtask : rdchk

  // Converter stand-in: one done per start, result 12'h800 where hm has a one, else 12'h100
  task automatic serve(input logic [31:0] sel, input logic [31:0] hm);
    int ch;
    int i;
    for (ch = 0; ch < NUM_CH; ch++) begin
      if (sel[ch]) begin
        for (i = 0; i < 20; i++) begin
          @(posedge pclk);
          if (conv_req.start === 1'b1) break;
        end
        if (i == 20) timeout();
        chk("conv channel", 32'(conv_req.channel), 32'(ch));
        // Generous fixed sample time, as a weak source would need
        repeat (2) @(posedge pclk);
        conv_rsp <= '{done: 1'b1, result: (hm[ch] ? 12'h800 : 12'h100)};
        @(posedge pclk);
        conv_rsp <= '{done: 1'b0, result: 12'h000};
      end
    end
  endtask : serve

  task automatic quiet(input int n);
    int cnt;
    cnt = 0;
    repeat (n) begin
      @(posedge pclk);
      if (conv_req.start === 1'b1) cnt++;
    end
    chk("unexpected starts", 32'(cnt), 32'h0000_0000);
  endtask : quiet

  task automatic pulse_first();
    @(posedge pclk);
    first_timer_evt <= 1'b1;
    @(posedge pclk);
    first_timer_evt <= 1'b0;
  endtask : pulse_first

  // ---------------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------------
  task automatic t_reset();
    rdchk("ctrl one reset", OFF_CTRL_ONE, RST_WORD);
    rdchk("ctrl five reset", OFF_CTRL_FIVE, RST_WORD);
    rdchk("unmapped data", 8'h40, 32'h0000_0000);
    chk("unmapped error", 32'(er), 32'h0000_0001);
    chk("irq reset", 32'(irq), 32'h0000_0000);
  endtask : t_reset

  task automatic t_disabled();
    wr(OFF_THRESH, 32'h0000_0400);
    wr(OFF_CTRL_ONE, 32'h0000_0060);
    wr(OFF_CTRL_FIVE, 32'h0000_0301);
    wr(OFF_SEL_LOW, 32'h0000_0007);
    pulse_first();
    quiet(12);
  endtask : t_disabled

  task automatic t_timer_sleep();
    sleep_mode <= 1'b1;
    wr(OFF_CTRL_FIVE, 32'h0000_8301);
    wr(OFF_SEL_LOW, 32'h0000_8003);
    wr(OFF_INT_MASK, 32'h0000_0001);
    pulse_first();
    serve(32'h0000_8003, 32'h0000_8000);
    quiet(8);
    rdchk("hit low", OFF_HIT_LOW, 32'h0000_8000);
    apb(1'b0, OFF_INT_STAT, 32'h0000_0000);
    chk("highest channel event", 32'(rd[0]), 32'h0000_0001);
    chk("irq on hit", 32'(irq), 32'h0000_0001);
    wr(OFF_INT_STAT, 32'h0000_0003);
    wr(OFF_HIT_LOW, 32'h0000_FFFF);
    pulse_first();
    serve(32'h0000_8003, 32'h0000_0000);
    quiet(8);
    chk("irq without hit", 32'(irq), 32'h0000_0000);
    sleep_mode <= 1'b0;
  endtask : t_timer_sleep

  task automatic t_pin_sleep();
    sleep_mode <= 1'b1;
    wr(OFF_CTRL_ONE, 32'h0000_0010);
    wr(OFF_SEL_LOW, 32'h0000_0007);
    @(posedge pclk);
    external_interrupt_zero <= 1'b1;
    serve(32'h0000_0007, 32'h0000_0002);
    external_interrupt_zero <= 1'b0;
    quiet(8);
    apb(1'b0, OFF_STATUS, 32'h0000_0000);
    chk("busy after scan", 32'(rd[0]), 32'h0000_0000);
    rdchk("hit low pin", OFF_HIT_LOW, 32'h0000_0002);
    sleep_mode <= 1'b0;
  endtask : t_pin_sleep

  task automatic t_other_idle();
    idle_mode <= 1'b1;
    wr(OFF_INT_STAT, 32'h0000_0003);
    wr(OFF_CTRL_ONE, 32'h0000_0070);
    wr(OFF_SEL_LOW, 32'h0000_0000);
    wr(OFF_SEL_HIGH, 32'h0000_0001);
    @(posedge pclk);
    other_timer_evt <= 1'b1;
    @(posedge pclk);
    other_timer_evt <= 1'b0;
    serve(32'h0001_0000, 32'h0001_0000);
    quiet(8);
    rdchk("hit high", OFF_HIT_HIGH, 32'h0000_0001);
    idle_mode <= 1'b0;
  endtask : t_other_idle

  task automatic t_soft_mask();
    wr(OFF_INT_MASK, 32'h0000_0000);
    wr(OFF_INT_STAT, 32'h0000_0003);
    wr(OFF_CTRL_ONE, 32'h0000_0002);
    serve(32'h0001_0000, 32'h0001_0000);
    quiet(8);
    apb(1'b0, OFF_INT_STAT, 32'h0000_0000);
    chk("soft hit event", 32'(rd[0]), 32'h0000_0001);
    chk("irq masked", 32'(irq), 32'h0000_0000);
    wr(OFF_INT_MASK, 32'h0000_0001);
    repeat (3) @(posedge pclk);
    chk("irq unmasked", 32'(irq), 32'h0000_0001);
    wr(OFF_INT_STAT, 32'h0000_0003);
    repeat (3) @(posedge pclk);
    chk("irq cleared", 32'(irq), 32'h0000_0000);
  endtask : t_soft_mask

  // End-of-scan modes, compare-below, abort and Sleep-halted timers
  task automatic t_end_modes();
    wr(OFF_INT_MASK, 32'h0000_0002);
    wr(OFF_HIT_HIGH, 32'h0000_FFFF);
    wr(OFF_CTRL_FIVE, 32'h0000_8200);
    wr(OFF_CTRL_ONE, 32'h0000_0002);
    serve(32'h0001_0000, 32'h0001_0000);
    quiet(8);
    rdchk("end event without hit", OFF_INT_STAT, 32'h0000_0000);
    wr(OFF_CTRL_ONE, 32'h0000_0002);
    serve(32'h0001_0000, 32'h0000_0000);
    quiet(8);
    rdchk("end event with hit", OFF_INT_STAT, 32'h0000_0002);
    chk("irq on scan end", 32'(irq), 32'h0000_0001);
    rdchk("hit high below", OFF_HIT_HIGH, 32'h0000_0001);
    wr(OFF_INT_STAT, 32'h0000_0003);
    wr(OFF_CTRL_FIVE, 32'h0000_8101);
    wr(OFF_CTRL_ONE, 32'h0000_0002);
    serve(32'h0001_0000, 32'h0000_0000);
    quiet(8);
    rdchk("end event every scan", OFF_INT_STAT, 32'h0000_0002);
    wr(OFF_INT_STAT, 32'h0000_0003);
    wr(OFF_CTRL_ONE, 32'h0000_0002);
    repeat (2) @(posedge pclk);
    chk("abort scan started", 32'(conv_req.start), 32'h0000_0001);
    wr(OFF_CTRL_FIVE, 32'h0000_0101);
    rdchk("status after abort", OFF_STATUS, 32'h0000_1000);
    @(posedge pclk);
    conv_rsp <= '{done: 1'b1, result: 12'h800};
    @(posedge pclk);
    conv_rsp <= '{done: 1'b0, result: 12'h000};
    quiet(4);
    rdchk("late done ignored", OFF_INT_STAT, 32'h0000_0000);
    sleep_mode <= 1'b1;
    wr(OFF_CTRL_FIVE, 32'h0000_8101);
    wr(OFF_CTRL_ONE, 32'h0000_0070);
    @(posedge pclk);
    other_timer_evt <= 1'b1;
    @(posedge pclk);
    other_timer_evt <= 1'b0;
    quiet(8);
    sleep_mode <= 1'b0;
  endtask : t_end_modes

  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    sleep_mode = 1'b0;
    idle_mode = 1'b0;
    first_timer_evt = 1'b0;
    other_timer_evt = 1'b0;
    external_interrupt_zero = 1'b0;
    conv_rsp = '{done: 1'b0, result: 12'h000};
    miscompares = 0;
    n_compared = 0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_disabled();
    t_timer_sleep();
    t_pin_sleep();
    t_other_idle();
    t_soft_mask();
    t_end_modes();
    close_out();
  end

endmodule : ats_autoscan_tb_top

`default_nettype wire
